/* rtl/dpm_pkg.sv */
// Package of constants and types for the drive protection monitor
// Functional notes
// RULE1: Thermal protection runs only when enabled.
// RULE2: Inverse-time thermal model cuts output.
// RULE3: One-minute level 50..200, default 150.
// RULE4: Continuous level 50..150, default 100.
// RULE5: Self-cooled motor derates cooling at low speed.
// RULE6: Warning uses percent level and seconds.
// RULE7: Output code 5 shows overload warning.
// RULE8: Overload trip only when enabled.
// RULE9: Trip above level for trip time.
// RULE10: Accel stall decelerates above stall level.
// RULE11: Constant-speed stall decelerates above level.
// RULE12: Decel stall holds ramp on high link.
// RULE13: Stall level percent 30..200, default 150.
// RULE14: Mask bits select accel, constant, decel.
// RULE15: Output code 7 shows stall always.
// RULE16: Phase-loss select decodes 0..3.
// RULE17: Output phase loss shuts output off.
// RULE18: Input loss or capacitor end blocks output.
// RULE19: Operator sets rated current correctly.
// RULE20: Any of eight inputs can be trip.
// RULE21: Code 18 closed contact trips.
// RULE22: Code 19 open contact trips.
// RULE23: Trips latch until fault reset.
package dpm_pkg;
    // Clock rate and one-second tick
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned SEC_CYCLES     = CLK_HZ;
    // Parameter ranges and defaults, in percent or seconds
    localparam logic [7:0]  THERM_1M_MIN   = 8'h32;
    localparam logic [7:0]  THERM_1M_MAX   = 8'hC8;
    localparam logic [7:0]  THERM_1M_DEF   = 8'h96;
    localparam logic [7:0]  THERM_CONT_MIN = 8'h32;
    localparam logic [7:0]  THERM_CONT_MAX = 8'h96;
    localparam logic [7:0]  THERM_CONT_DEF = 8'h64;
    localparam logic [7:0]  WARN_LVL_MIN   = 8'h1E;
    localparam logic [7:0]  WARN_LVL_MAX   = 8'h96;
    localparam logic [7:0]  WARN_LVL_DEF   = 8'h96;
    localparam logic [5:0]  WARN_TIME_MAX  = 6'h1E;
    localparam logic [5:0]  WARN_TIME_DEF  = 6'h0A;
    localparam logic [7:0]  TRIP_LVL_MIN   = 8'h1E;
    localparam logic [7:0]  TRIP_LVL_MAX   = 8'hC8;
    localparam logic [7:0]  TRIP_LVL_DEF   = 8'hB4;
    localparam logic [5:0]  TRIP_TIME_MAX  = 6'h3C;
    localparam logic [5:0]  TRIP_TIME_DEF  = 6'h3C;
    localparam logic [7:0]  STALL_LVL_MIN  = 8'h1E;
    localparam logic [7:0]  STALL_LVL_MAX  = 8'hC8;
    localparam logic [7:0]  STALL_LVL_DEF  = 8'h96;
    // Thermal bucket: full after 60 s at the one-minute excess
    localparam logic [31:0] THERM_FULL     = 32'h0000_003C;
    // Self-cooled derating: below this speed percent add penalty
    localparam logic [7:0]  LOW_SPEED_PCT  = 8'h32;
    localparam logic [7:0]  COOL_PENALTY   = 8'h0A;
    // Output and input function codes
    localparam logic [4:0]  OUT_FN_WARN    = 5'h05;
    localparam logic [4:0]  OUT_FN_STALL   = 5'h07;
    localparam logic [4:0]  IN_FN_TRIP_NO  = 5'h12;
    localparam logic [4:0]  IN_FN_TRIP_NC  = 5'h13;
    localparam logic [4:0]  IN_FN_MAX      = 5'h19;
    localparam int unsigned NUM_INPUTS     = 8;
    // Stall mask bit positions
    localparam int unsigned STALL_BIT_ACC  = 0;
    localparam int unsigned STALL_BIT_CON  = 1;
    localparam int unsigned STALL_BIT_DEC  = 2;
    // Phase-loss selection bits
    localparam int unsigned PL_BIT_OUT     = 0;
    localparam int unsigned PL_BIT_IN      = 1;
    // Ramp phase one-hot
    typedef enum logic [3:0] {
        DPM_RAMP_STOP  = 4'h1,
        DPM_RAMP_ACC   = 4'h2,
        DPM_RAMP_CONST = 4'h4,
        DPM_RAMP_DEC   = 4'h8
    } dpm_ramp_t;
    // Trip cause index
    localparam int unsigned TRIP_THERM     = 0;
    localparam int unsigned TRIP_OVLD      = 1;
    localparam int unsigned TRIP_OPL       = 2;
    localparam int unsigned TRIP_IPL       = 3;
    localparam int unsigned TRIP_EXT       = 4;
    localparam int unsigned NUM_TRIPS      = 5;
endpackage

/* rtl/dpm_sync.sv */
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module dpm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;  // First stage, read only by second
    // Two stages, reset to zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* rtl/dpm_timer.sv */
// Seconds timer: counts how long a condition has held
`timescale 1ns/10ps
module dpm_timer
    import dpm_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cond,
    input  wire logic [5:0] limit_sec,
    output logic            expired
);
    logic [31:0] tick_q;  // Cycles within the current second
    logic [5:0]  sec_q;   // Whole seconds the condition held
    // Count while held; any drop restarts the wait
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !cond) begin
            tick_q <= '0;
            sec_q  <= '0;
        end else if (sec_q < limit_sec) begin
            if (tick_q == SEC_CYC - 1) begin
                tick_q <= '0;
                sec_q  <= sec_q + 6'h01;
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end
    // Zero time means immediate once the condition holds
    assign expired = cond && (sec_q >= limit_sec);
endmodule

/* rtl/dpm_monitor.sv */
// Top of the drive protection monitor
`timescale 1ns/10ps
module dpm_monitor
    import dpm_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Measurements, same clock domain
    input  wire logic [7:0]  motor_current_pct,
    input  wire logic [7:0]  motor_speed_pct,
    input  wire logic        dc_link_over_limit,
    input  wire logic [3:0]  ramp_phase,
    // Asynchronous sense and contact pins
    input  wire logic [2:0]  output_phase_lost,
    input  wire logic [2:0]  input_phase_lost,
    input  wire logic        capacitor_worn,
    input  wire logic [7:0]  contact_in,
    // Configuration
    input  wire logic        thermal_enable,
    input  wire logic [7:0]  thermal_one_minute_level,
    input  wire logic [7:0]  thermal_continuous_level,
    input  wire logic        motor_cooling_type,
    input  wire logic [7:0]  overload_warn_level,
    input  wire logic [5:0]  overload_warn_time,
    input  wire logic        overload_trip_enable,
    input  wire logic [7:0]  overload_trip_level,
    input  wire logic [5:0]  overload_trip_time,
    input  wire logic [2:0]  stall_mode_mask,
    input  wire logic [7:0]  stall_current_level,
    input  wire logic [1:0]  phase_loss_select,
    input  wire logic [4:0]  transistor_output_function,
    input  wire logic [4:0]  relay_output_function,
    input  wire logic [39:0] input_function,
    input  wire logic        config_load,
    input  wire logic        fault_reset,
    // Results
    output logic             output_enable,
    output logic             ramp_decelerate,
    output logic             ramp_hold,
    output logic             open_collector_output,
    output logic             relay_contacts,
    output logic             overload_warning,
    output logic             stall_active,
    output logic [4:0]       fault_flags,
    output logic             config_refused
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] opl_s;    // Output phase loss, synced
    logic [2:0] ipl_s;    // Input phase loss, synced
    logic       cap_s;    // Capacitor end of life, synced
    logic [7:0] cont_s;   // Contact levels, synced

    dpm_sync #(.W(15)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({output_phase_lost, input_phase_lost, capacitor_worn,
                    contact_in}),
        .sync_out ({opl_s, ipl_s, cap_s, cont_s})
    );

    logic [1:0] pin_age_q;  // Sync stages refilled since reset

    // Stages read zero right after reset; an NC contact would look
    // open and latch a false trip, so pin trips wait for real samples
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_age_q <= 2'h0;
        end else begin
            pin_age_q <= {pin_age_q[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accepted configuration
    logic [7:0] th1m_q;   // One-minute level in use
    logic [7:0] thc_q;    // Continuous level in use
    logic [7:0] wlvl_q;   // Warning level in use
    logic [5:0] wtim_q;   // Warning time in use
    logic [7:0] tlvl_q;   // Trip level in use
    logic [5:0] ttim_q;   // Trip time in use
    logic [7:0] slvl_q;   // Stall level in use
    logic       cfg_ok;   // Offered set is legal

    // Range checks; the ordering of the two thermal levels matters
    always_comb begin
        cfg_ok = (thermal_one_minute_level >= THERM_1M_MIN) &&
                 (thermal_one_minute_level <= THERM_1M_MAX) &&
                 (thermal_continuous_level >= THERM_CONT_MIN) &&
                 (thermal_continuous_level <= THERM_CONT_MAX) &&
                 (thermal_one_minute_level >=
                  thermal_continuous_level) &&           // RULE3 RULE4
                 (overload_warn_level >= WARN_LVL_MIN) &&
                 (overload_warn_level <= WARN_LVL_MAX) &&
                 (overload_warn_time <= WARN_TIME_MAX) &&  // RULE6
                 (overload_trip_level >= TRIP_LVL_MIN) &&
                 (overload_trip_level <= TRIP_LVL_MAX) &&
                 (overload_trip_time <= TRIP_TIME_MAX) &&  // RULE9
                 (stall_current_level >= STALL_LVL_MIN) &&
                 (stall_current_level <= STALL_LVL_MAX);   // RULE13
    end

    // Load only a legal set; a refused set keeps the old one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            th1m_q         <= THERM_1M_DEF;
            thc_q          <= THERM_CONT_DEF;
            wlvl_q         <= WARN_LVL_DEF;
            wtim_q         <= WARN_TIME_DEF;
            tlvl_q         <= TRIP_LVL_DEF;
            ttim_q         <= TRIP_TIME_DEF;
            slvl_q         <= STALL_LVL_DEF;
            config_refused <= 1'b0;
        end else if (config_load) begin
            config_refused <= !cfg_ok;                  // RULE3 RULE4
            if (cfg_ok) begin
                th1m_q <= thermal_one_minute_level;
                thc_q  <= thermal_continuous_level;
                wlvl_q <= overload_warn_level;
                wtim_q <= overload_warn_time;
                tlvl_q <= overload_trip_level;
                ttim_q <= overload_trip_time;
                slvl_q <= stall_current_level;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Electronic thermal model
    logic [7:0]  eff_cur;   // Current with cooling derating
    logic [7:0]  th_span;   // One-minute excess over continuous
    logic [31:0] sec_cnt_q; // One-second prescaler
    logic        sec_tick;  // One pulse per second
    logic [31:0] heat_q;    // Accumulated heat, in excess-seconds
    logic        th_hot;    // Bucket full

    // Self-cooled motors see current as higher at low speed
    always_comb begin
        eff_cur = motor_current_pct;
        if (!motor_cooling_type && motor_speed_pct < LOW_SPEED_PCT &&
            motor_current_pct <= 8'hFF - COOL_PENALTY) begin
            eff_cur = motor_current_pct + COOL_PENALTY;  // RULE5
        end
        th_span = th1m_q - thc_q;
    end

    // Free-running one-second tick, used only by the thermal integrator
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sec_cnt_q == SEC_CYC - 1) begin
            sec_cnt_q <= '0;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
        end
    end
    assign sec_tick = (sec_cnt_q == SEC_CYC - 1);

    // Heat rises by the excess each second, cools by one unit at or below;
    // larger excess fills faster, giving an inverse-time curve
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !thermal_enable) begin
            heat_q <= '0;                               // RULE1
        end else if (sec_tick) begin
            if (eff_cur > thc_q) begin
                heat_q <= heat_q + 32'(eff_cur - thc_q); // RULE2
            end else if (heat_q != '0) begin
                heat_q <= heat_q - 32'h1;
            end
        end
    end
    // Full when heat reaches one minute at the one-minute level
    assign th_hot = thermal_enable && (th_span != 8'h00) &&
                    (heat_q >= THERM_FULL * 32'(th_span)); // RULE1 RULE2

    ////////////////////////////////////////////////////////////////////
    // Overload warning and trip timers
    logic warn_exp;   // Warning held long enough
    logic ovl_exp;    // Trip condition held long enough

    dpm_timer #(.SEC_CYC(SEC_CYC)) u_warn (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .cond      (motor_current_pct > wlvl_q),
        .limit_sec (wtim_q),
        .expired   (warn_exp)
    );

    dpm_timer #(.SEC_CYC(SEC_CYC)) u_trip (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .cond      (overload_trip_enable &&
                    motor_current_pct > tlvl_q),
        .limit_sec (ttim_q),
        .expired   (ovl_exp)
    );

    ////////////////////////////////////////////////////////////////////
    // External trip decode
    logic [NUM_INPUTS-1:0] ext_hit;  // Per input trip request

    // Any input may carry either trip code
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_ext
            logic [4:0] fn;
            assign fn = input_function[gi*5 +: 5];    // RULE20
            assign ext_hit[gi] =
                ((fn == IN_FN_TRIP_NO) && cont_s[gi]) ||  // RULE21
                ((fn == IN_FN_TRIP_NC) && !cont_s[gi]);   // RULE22
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Fault latches
    logic [NUM_TRIPS-1:0] trip_now;  // Live trip causes

    always_comb begin
        trip_now             = '0;
        trip_now[TRIP_THERM] = th_hot;
        trip_now[TRIP_OVLD]  = ovl_exp;                        // RULE8
        trip_now[TRIP_OPL]   = pin_age_q[1] &&
                               phase_loss_select[PL_BIT_OUT] &&
                               (|opl_s);                  // RULE16 RULE17
        trip_now[TRIP_IPL]   = pin_age_q[1] &&
                               phase_loss_select[PL_BIT_IN] &&
                               ((|ipl_s) || cap_s);       // RULE16 RULE18
        trip_now[TRIP_EXT]   = pin_age_q[1] && (|ext_hit);
    end

    // A live cause wins over a reset in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_flags <= '0;
        end else if (fault_reset) begin
            fault_flags <= trip_now;                      // RULE23
        end else begin
            fault_flags <= fault_flags | trip_now;        // RULE23
        end
    end

    // Output stays off while any latched or live fault stands
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= !(|trip_now) &&
                             (fault_reset || !(|fault_flags)); // RULE23
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stall prevention
    logic stall_acc;   // Accel over-current
    logic stall_con;   // Constant-speed over-current
    logic stall_dec;   // Decel with high link voltage

    assign stall_acc = (ramp_phase == DPM_RAMP_ACC) &&
                       (motor_current_pct > slvl_q);
    assign stall_con = (ramp_phase == DPM_RAMP_CONST) &&
                       (motor_current_pct > slvl_q);
    assign stall_dec = (ramp_phase == DPM_RAMP_DEC) && dc_link_over_limit;

    // Ramp commands only when the phase bit is set
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ramp_decelerate <= 1'b0;
            ramp_hold       <= 1'b0;
        end else begin
            ramp_decelerate <=
                (stall_acc && stall_mode_mask[STALL_BIT_ACC]) ||  // RULE10
                (stall_con && stall_mode_mask[STALL_BIT_CON]);    // RULE11
            ramp_hold <= stall_dec &&
                         stall_mode_mask[STALL_BIT_DEC];    // RULE12 RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Live status and output terminals
    logic stall_cond;  // Stall condition regardless of mask

    assign stall_cond = stall_acc || stall_con || stall_dec;  // RULE15

    // Status follows live conditions, no latching
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            overload_warning      <= 1'b0;
            stall_active          <= 1'b0;
            open_collector_output <= 1'b0;
            relay_contacts        <= 1'b0;
        end else begin
            overload_warning      <= warn_exp;
            stall_active          <= stall_cond;
            open_collector_output <=
                ((transistor_output_function == OUT_FN_WARN) &&
                 warn_exp) ||                                 // RULE7
                ((transistor_output_function == OUT_FN_STALL) &&
                 stall_cond);                                 // RULE15
            relay_contacts <=
                ((relay_output_function == OUT_FN_WARN) && warn_exp) ||
                ((relay_output_function == OUT_FN_STALL) && stall_cond);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    // One clock domain: shared clock and reset for the checks below
    default clocking cb_dpm @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_thermal_gate: assert property ( // RULE1
        !thermal_enable |=>
            !fault_flags[TRIP_THERM] || $past(fault_flags[TRIP_THERM]))
        else $error("thermal fault set while disabled");
    a_trip_cuts: assert property ( // RULE23
        (|trip_now) |=> !output_enable)
        else $error("output stayed on during trip");
    a_latch_hold: assert property ( // RULE23
        (fault_flags[TRIP_EXT] && !fault_reset) |=> fault_flags[TRIP_EXT])
        else $error("fault cleared without reset");
    a_ext_no: assert property ( // RULE21
        (pin_age_q[1] && input_function[4:0] == IN_FN_TRIP_NO && cont_s[0])
        |=> fault_flags[TRIP_EXT])
        else $error("closed trip contact not latched");
    a_ext_nc: assert property ( // RULE22
        (pin_age_q[1] && input_function[4:0] == IN_FN_TRIP_NC && !cont_s[0])
        |=> fault_flags[TRIP_EXT])
        else $error("open trip contact not latched");
    a_opl_trip: assert property ( // RULE17
        (pin_age_q[1] && phase_loss_select[PL_BIT_OUT] && |opl_s)
        |=> fault_flags[TRIP_OPL])
        else $error("output phase loss missed");
    a_ipl_off: assert property ( // RULE16
        !phase_loss_select[PL_BIT_IN] |-> !trip_now[TRIP_IPL])
        else $error("input phase loss while disabled");
    a_ovl_gate: assert property ( // RULE8
        !overload_trip_enable |-> !ovl_exp)
        else $error("overload timer ran while disabled");
    a_stall_acc: assert property ( // RULE10
        (stall_acc && stall_mode_mask[STALL_BIT_ACC]) |=> ramp_decelerate)
        else $error("no decel on accel stall");
    a_stall_con: assert property ( // RULE11
        (stall_con && stall_mode_mask[STALL_BIT_CON]) |=> ramp_decelerate)
        else $error("no decel on constant-speed stall");
    a_stall_dec: assert property ( // RULE12
        (stall_dec && !stall_mode_mask[STALL_BIT_DEC]) |=> !ramp_hold)
        else $error("hold without mask bit");
    a_warn_out: assert property ( // RULE7
        (transistor_output_function == OUT_FN_WARN && warn_exp)
        |=> open_collector_output)
        else $error("warning not shown on output");
    a_stall_out: assert property ( // RULE15
        (transistor_output_function == OUT_FN_STALL && stall_cond)
        |=> open_collector_output)
        else $error("stall not shown on output");
    a_cfg_refuse: assert property ( // RULE3
        (config_load && thermal_one_minute_level < thermal_continuous_level)
        |=> config_refused && $stable(th1m_q))
        else $error("illegal thermal levels accepted");
    c_ext_trip: cover property (@(posedge sys_clk) fault_flags[TRIP_EXT]);
    c_warn: cover property (@(posedge sys_clk) overload_warning);
    c_hold: cover property (@(posedge sys_clk) ramp_hold);
    c_rearm: cover property (@(posedge sys_clk)
        !output_enable ##1 output_enable);
endmodule

/* dv/dpm_far_side.sv */
// Far-side model: current sensing, ramp controller, contacts
`timescale 1ns/10ps
module dpm_far_side (
    input  wire logic       sys_clk,
    input  wire logic [7:0] amps_req,
    input  wire logic [3:0] phase_req,
    input  wire logic [7:0] closed_req,
    output logic      [7:0] motor_current_pct,
    output logic      [3:0] ramp_phase,
    output logic      [7:0] contact_in
);
    // Sensor reads in percent of the programmed rated current
    always_ff @(posedge sys_clk) begin
        motor_current_pct <= amps_req;
    end
    // Ramp controller reports its phase one cycle late
    always_ff @(posedge sys_clk) begin
        ramp_phase <= phase_req;
    end
    // Contacts bounce-free here; a real bank would chatter
    always_ff @(posedge sys_clk) begin
        contact_in <= closed_req;
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the drive protection monitor
`timescale 1ns/10ps
module tb_top;
    import dpm_pkg::*;
    logic sys_clk, rst_n, dcl, ten, oten, cld, frst, cap;
    logic [7:0]  amps, t1m, tcon, wlv, tlv, slv, closed, cur, cin, spd;
    logic [5:0]  wtm, ttm;
    logic [3:0]  ph, phw;
    logic [2:0]  opl, ipl, smask;
    logic [1:0]  plsel;
    logic [4:0]  tfn, rfn, ff;
    logic [39:0] ifn;
    logic        oe, rdec, rhold, oco, rly, owarn, stl, crf;
    int          miscompares, checks_done, k, i;
    // Short second so timed trips finish quickly
    dpm_monitor #(.SEC_CYC(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .motor_current_pct(cur), .motor_speed_pct(spd),
        .dc_link_over_limit(dcl), .ramp_phase(phw),
        .output_phase_lost(opl), .input_phase_lost(ipl),
        .capacitor_worn(cap), .contact_in(cin),
        .thermal_enable(ten), .thermal_one_minute_level(t1m),
        .thermal_continuous_level(tcon), .motor_cooling_type(1'b0),
        .overload_warn_level(wlv), .overload_warn_time(wtm),
        .overload_trip_enable(oten), .overload_trip_level(tlv),
        .overload_trip_time(ttm), .stall_mode_mask(smask),
        .stall_current_level(slv), .phase_loss_select(plsel),
        .transistor_output_function(tfn), .relay_output_function(rfn),
        .input_function(ifn), .config_load(cld), .fault_reset(frst),
        .output_enable(oe), .ramp_decelerate(rdec), .ramp_hold(rhold),
        .open_collector_output(oco), .relay_contacts(rly),
        .overload_warning(owarn), .stall_active(stl),
        .fault_flags(ff), .config_refused(crf));
    dpm_far_side far (.sys_clk(sys_clk), .amps_req(amps),
        .phase_req(ph), .closed_req(closed), .motor_current_pct(cur),
        .ramp_phase(phw), .contact_in(cin));
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %b want %b", $time, got, exp);
        end
    endtask
    // Stall outputs {decel, hold, status}: hold only in the decel phase
    function automatic logic [4:0] stall_exp(input int ph_i);
        return (ph_i == 2) ? 5'h3 : 5'h5;
    endfunction
    // Inputs move a fixed 2 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic pulse_reset();
        frst = 1'b1;
        cyc(1);
        frst = 1'b0;
        cyc(2);
    endtask
    task automatic load(input logic [7:0] a, b, w);
        t1m = a;
        tcon = b;
        wlv = w;
        cld = 1'b1;
        cyc(1);
        cld = 1'b0;
        cyc(1);
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Whole run needs about 500 cycles
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(44));
        {rst_n, dcl, ten, cld, frst, cap, opl, ipl, smask, plsel} = '0;
        {tfn, rfn, ifn, closed, amps} = '0;
        spd = 8'h64;
        {oten, ph, t1m, tcon, wlv, wtm} = {1'b1, 4'h1, 8'h96, 8'h64,
                                            8'h96, 6'h0A};
        {tlv, ttm, slv} = {8'hB4, 6'h3C, 8'h96};
        cyc(6);
        chk(ff, 5'h00);
        rst_n = 1'b1;
        cyc(3);
        chk(5'(oe), 5'h01);
        // Both contact kinds on a random input
        k = $urandom % 8;
        for (i = 0; i < 2; i++) begin
            // Settle the contact before arming its code
            ifn = '0;
            closed = (i == 0) ? 8'h00 : 8'h01 << k;
            cyc(4);
            ifn = 40'(IN_FN_TRIP_NO + 5'(i)) << (5 * k);
            cyc(5);
            chk(ff, 5'h00);
            closed = ~closed & (8'h01 << k);
            cyc(5);
            chk(5'({ff[4], oe}), 5'h02);
            closed = ~closed & (8'h01 << k);
            cyc(4);
            chk(ff, 5'h10);
            pulse_reset();
            chk(ff, 5'h00);
            chk(5'(oe), 5'h01);
        end
        // Stall per ramp phase, then with the mask cleared
        tfn = OUT_FN_STALL;
        for (i = 0; i < 3; i++) begin
            ph = 4'h2 << i;
            smask = 3'h1 << i;
            dcl = (i == 2);
            amps = 8'(151 + $urandom % 29);
            cyc(5);
            chk(5'({rdec, rhold, stl}), stall_exp(i));
            smask = 3'h0;
            cyc(4);
            chk(5'({rdec, rhold, stl}), 5'h1);
            if (i == 0) chk(5'(oco), 5'h1);
            amps = 8'h00;
            cyc(4);
        end
        {dcl, ph, tfn} = {1'b0, 4'h1, 5'h00};
        // Every phase-loss selection; the last has a worn capacitor in place of input loss
        for (i = 0; i < 4; i++) begin
            plsel = 2'(i);
            opl = 3'h1 << ($urandom % 3);
            ipl = (i == 3) ? 3'h0 : 3'h1 << ($urandom % 3);
            cap = (i == 3);
            cyc(5);
            chk(5'({ff[3:2], oe}), 5'({2'(i), i == 0}));
            {opl, ipl, cap} = '0;
            cyc(4);
            pulse_reset();
        end
        plsel = 2'h0;
        load(8'h5A, 8'h64, 8'h64);
        chk(5'(crf), 5'h1);
        load(8'h96, 8'h64, 8'h14);
        chk(5'(crf), 5'h1);
        wtm = 6'h00;
        {tlv, ttm} = {8'h78, 6'h02};
        load(8'h96, 8'h64, 8'h64);
        chk(5'(crf), 5'h0);
        // Immediate warning on the relay; timed trip only when enabled
        rfn = OUT_FN_WARN;
        oten = 1'b0;
        amps = 8'h82;
        cyc(4);
        chk(5'({rly, owarn}), 5'h3);
        cyc(30);
        chk(ff, 5'h00);
        amps = 8'h00;
        cyc(3);
        oten = 1'b1;
        amps = 8'h82;
        cyc(15);
        chk(5'(ff[1]), 5'h0);
        cyc(10);
        chk(5'({ff[1], oe}), 5'h2);
        {amps, oten} = '0;
        cyc(3);
        pulse_reset();
        // Self-cooled at low speed: derated, full after 28 s not 30 s
        {ten, spd} = {1'b1, 8'h14};
        amps = 8'hC8;
        cyc(250);
        chk(5'(ff[0]), 5'h0);
        cyc(35);
        chk(5'({ff[0], oe}), 5'h2);
        finish_test();
    end
endmodule
